// ---- verilog/icu_defines.svh ----
/*
 * Offsets, field positions, reset values and select codes of the input capture unit.
 * Assumes a word-aligned APB slave decoding the low 8 address bits of the block.
 */
`ifndef ICU_DEFINES_SVH
`define ICU_DEFINES_SVH

// register offsets (byte addresses within the block)
`define ICU_OFF_TIMER_CFG 8'h00
`define ICU_OFF_TIMER_PHASE 8'h04
`define ICU_OFF_CH_CFG0 8'h08
`define ICU_OFF_STAMP0 8'h14
`define ICU_OFF_STATUS 8'h20
`define ICU_OFF_TIMER_VALUE 8'h24
`define ICU_CH_STRIDE 8'h04

// capture timer configuration fields
`define ICU_TCFG_EN 0
`define ICU_TCFG_SYNC_EN 1
`define ICU_TCFG_SEL_LO 2
`define ICU_TCFG_SEL_HI 4
`define ICU_TCFG_SW_SYNC 5

// sync source codes: 0..2 pick a pwm timer sync output
`define ICU_SYNC_SEL_EXT 3'h3

// channel configuration fields
`define ICU_CCFG_EN 0
`define ICU_CCFG_RISE 1
`define ICU_CCFG_FALL 2
`define ICU_CCFG_PS_LO 3
`define ICU_CCFG_PS_HI 10
`define ICU_CCFG_INV 11
`define ICU_CCFG_FORCE 12

// status fields
`define ICU_STAT_EDGE_LO 0
`define ICU_STAT_LVL_LO 3
`define ICU_STAT_RUN 6

// reset values and sizes
`define ICU_RST_WORD 32'h0000_0000
`define ICU_NUM_CH 3
`define ICU_SYNC_W 4
// nominal bus clock of the timer in the target system
`define ICU_BUS_CLK_NOMINAL_MHZ 80

`endif

// ---- verilog/icu_pkg.sv ----
/*
 * Types of the input capture unit: channel settings and the state of each module.
 * Assumes icu_defines.svh is compiled with it.
 */
`include "icu_defines.svh"

package icu_pkg;

  // settings of one capture channel
  typedef struct packed {
    logic enable;
    logic invert;
    logic [7:0] prescale;
    logic rise_en;
    logic fall_en;
  } icu_chcfg_s;

  // state of the two-stage synchroniser
  typedef struct packed {
    logic [`ICU_SYNC_W-1:0] s1;
    logic [`ICU_SYNC_W-1:0] s2;
  } icu_sync_s;

  // state of one capture channel
  typedef struct packed {
    logic level;
    logic [7:0] count;
    logic capture;
    logic edge_fall;
  } icu_chan_s;

  // state of the top level
  typedef struct packed {
    logic timer_en;
    logic sync_en;
    logic [2:0] sync_sel;
    logic sw_sync;
    logic [31:0] phase;
    logic [31:0] timer;
    icu_chcfg_s [`ICU_NUM_CH-1:0] chcfg;
    logic [`ICU_NUM_CH-1:0][31:0] stamp;
    logic [`ICU_NUM_CH-1:0] last_edge;
    logic [`ICU_NUM_CH-1:0] sw_force;
    logic [`ICU_NUM_CH-1:0] irq;
    logic ext_prev;
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
  } icu_top_s;

endpackage

// ---- verilog/icu_sync2.sv ----
/*
 * Two-flip-flop synchroniser for the pad inputs of the capture unit.
 * Assumes inputs asynchronous to pclk; only the second stage is read.
 */
`timescale 1ns/1ns
`include "icu_defines.svh"

module icu_sync2 (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic [`ICU_SYNC_W-1:0] async_in,
  output logic [`ICU_SYNC_W-1:0] sync_out
);

  icu_pkg::icu_sync_s s_r;
  icu_pkg::icu_sync_s s_nxt;

  // first stage feeds only the second stage
  always_comb begin
    s_nxt = s_r;
    s_nxt.s1 = async_in;
    s_nxt.s2 = s_r.s1;
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      s_r <= '0;
    end else begin
      s_r <= s_nxt;
    end
  end

  assign sync_out = s_r.s2;

endmodule // icu_sync2

// ---- verilog/icu_channel.sv ----
/*
 * One capture channel: optional inversion, edge prescaler and edge qualification.
 * Assumes a synchronised pad level and settings held in the top level's registers.
 */
`timescale 1ns/1ns
`include "icu_defines.svh"

module icu_channel (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic pad_sync,
  input icu_pkg::icu_chcfg_s cfg,
  input wire logic sw_force,
  output logic capture,
  output logic edge_fall
);

  icu_pkg::icu_chan_s s_r;
  icu_pkg::icu_chan_s s_nxt;
  logic lvl;
  logic rise;
  logic fall;
  logic qual;

  // invert first, then edges of the preprocessed level
  assign lvl = pad_sync ^ cfg.invert;
  assign rise = lvl & ~s_r.level;
  assign fall = ~lvl & s_r.level;
  // only selected edges count toward the prescaler
  assign qual = cfg.enable & ((rise & cfg.rise_en) | (fall & cfg.fall_en));

  // prescaler passes one qualifying edge in every prescale+1
  always_comb begin
    s_nxt = s_r;
    s_nxt.capture = 1'b0;
    s_nxt.level = lvl;
    if (!cfg.enable) begin
      s_nxt.count = 8'h00;
    end else if (qual) begin
      if (s_r.count == cfg.prescale) begin
        s_nxt.count = 8'h00;
        s_nxt.capture = 1'b1;
        s_nxt.edge_fall = fall;
      end else begin
        s_nxt.count = s_r.count + 8'h01;
      end
    end
    // a forced capture keeps the recorded edge
    if (sw_force) begin
      s_nxt.capture = 1'b1;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      s_r <= '0;
    end else begin
      s_r <= s_nxt;
    end
  end

  assign capture = s_r.capture;
  assign edge_fall = s_r.edge_fall;

endmodule // icu_channel

// ---- verilog/icu_top.sv ----
/*
 * Input capture unit: shared 32-bit capture timer, three capture channels, APB registers.
 * Assumes pads already routed to the capture inputs, pwm timer sync pulses on pclk,
 * and an APB master that holds each request until pready.
 */
// Decided for this implementation: the address map and the APB register port.
`timescale 1ns/1ns
`include "icu_defines.svh"

module icu_top (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic [7:0] paddr,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic capture_input_a,
  input wire logic capture_input_b,
  input wire logic capture_input_c,
  input wire logic [2:0] pwm_timer_sync,
  input wire logic ext_sync_in,
  output logic [2:0] capture_irq
);

  icu_pkg::icu_top_s s_r;
  icu_pkg::icu_top_s s_nxt;

  logic [`ICU_SYNC_W-1:0] pad_raw;
  logic [`ICU_SYNC_W-1:0] pad_sync;
  logic [`ICU_NUM_CH-1:0] ch_capture;
  logic [`ICU_NUM_CH-1:0] ch_edge_fall;
  logic ext_sync_s;
  logic access;
  logic wr_done;
  logic hit;
  logic [31:0] rd_word;
  logic sel_hit;
  logic sync_evt;

  // pads and the external sync input cross into pclk through two flops
  assign pad_raw = {ext_sync_in, capture_input_c, capture_input_b, capture_input_a};

  icu_sync2 u_sync (
    .pclk(pclk),
    .presetn(presetn),
    .async_in(pad_raw),
    .sync_out(pad_sync)
  );

  assign ext_sync_s = pad_sync[`ICU_SYNC_W-1];

  // one channel per capture input, each with its own settings
  genvar gi;
  generate
    for (gi = 0; gi < `ICU_NUM_CH; gi++) begin : g_ch
      icu_channel u_ch (
        .pclk(pclk),
        .presetn(presetn),
        .pad_sync(pad_sync[gi]),
        .cfg(s_r.chcfg[gi]),
        .sw_force(s_r.sw_force[gi]),
        .capture(ch_capture[gi]),
        .edge_fall(ch_edge_fall[gi])
      );
    end
  endgenerate

  // apb phases: the access phase waits one cycle, then completes
  assign access = psel & penable & ~s_r.pready;
  assign wr_done = psel & penable & s_r.pready & pwrite;

  // register decode, apb answer, timer and capture bookkeeping
  always_comb begin
    s_nxt = s_r;
    hit = 1'b0;
    rd_word = `ICU_RST_WORD;
    sel_hit = 1'b0;
    sync_evt = 1'b0;

    // read decode; unmapped or misaligned addresses miss
    if (paddr == `ICU_OFF_TIMER_CFG) begin
      hit = 1'b1;
      rd_word[`ICU_TCFG_EN] = s_r.timer_en;
      rd_word[`ICU_TCFG_SYNC_EN] = s_r.sync_en;
      rd_word[`ICU_TCFG_SEL_HI:`ICU_TCFG_SEL_LO] = s_r.sync_sel;
    end else if (paddr == `ICU_OFF_TIMER_PHASE) begin
      hit = 1'b1;
      rd_word = s_r.phase;
    end else if (paddr == `ICU_OFF_STATUS) begin
      hit = 1'b1;
      rd_word[`ICU_STAT_EDGE_LO +: `ICU_NUM_CH] = s_r.last_edge;
      rd_word[`ICU_STAT_LVL_LO +: `ICU_NUM_CH] = pad_sync[`ICU_NUM_CH-1:0];
      rd_word[`ICU_STAT_RUN] = s_r.timer_en;
    end else if (paddr == `ICU_OFF_TIMER_VALUE) begin
      hit = 1'b1;
      rd_word = s_r.timer;
    end
    for (int i = 0; i < `ICU_NUM_CH; i++) begin
      if (paddr == 8'(`ICU_OFF_CH_CFG0 + `ICU_CH_STRIDE * 8'(i))) begin
        hit = 1'b1;
        rd_word[`ICU_CCFG_EN] = s_r.chcfg[i].enable;
        rd_word[`ICU_CCFG_RISE] = s_r.chcfg[i].rise_en;
        rd_word[`ICU_CCFG_FALL] = s_r.chcfg[i].fall_en;
        rd_word[`ICU_CCFG_PS_HI:`ICU_CCFG_PS_LO] = s_r.chcfg[i].prescale;
        rd_word[`ICU_CCFG_INV] = s_r.chcfg[i].invert;
      end
      if (paddr == 8'(`ICU_OFF_STAMP0 + `ICU_CH_STRIDE * 8'(i))) begin
        hit = 1'b1;
        rd_word = s_r.stamp[i];
      end
    end

    // answer one cycle into the access phase, then release
    if (access) begin
      s_nxt.pready = 1'b1;
      s_nxt.pslverr = ~hit;
      s_nxt.prdata = (pwrite || !hit) ? `ICU_RST_WORD : rd_word;
    end else begin
      s_nxt.pready = 1'b0;
      s_nxt.pslverr = 1'b0;
      s_nxt.prdata = `ICU_RST_WORD;
    end

    // one-cycle command pulses
    s_nxt.sw_sync = 1'b0;
    s_nxt.sw_force = '0;

    // writes take effect at the completing edge; read-only words ignore them
    if (wr_done) begin
      if (paddr == `ICU_OFF_TIMER_CFG) begin
        s_nxt.timer_en = pwdata[`ICU_TCFG_EN];
        s_nxt.sync_en = pwdata[`ICU_TCFG_SYNC_EN];
        s_nxt.sync_sel = pwdata[`ICU_TCFG_SEL_HI:`ICU_TCFG_SEL_LO];
        s_nxt.sw_sync = pwdata[`ICU_TCFG_SW_SYNC];
      end
      if (paddr == `ICU_OFF_TIMER_PHASE) begin
        s_nxt.phase = pwdata;
      end
      for (int i = 0; i < `ICU_NUM_CH; i++) begin
        if (paddr == 8'(`ICU_OFF_CH_CFG0 + `ICU_CH_STRIDE * 8'(i))) begin
          s_nxt.chcfg[i].enable = pwdata[`ICU_CCFG_EN];
          s_nxt.chcfg[i].rise_en = pwdata[`ICU_CCFG_RISE];
          s_nxt.chcfg[i].fall_en = pwdata[`ICU_CCFG_FALL];
          s_nxt.chcfg[i].prescale = pwdata[`ICU_CCFG_PS_HI:`ICU_CCFG_PS_LO];
          s_nxt.chcfg[i].invert = pwdata[`ICU_CCFG_INV];
          s_nxt.sw_force[i] = pwdata[`ICU_CCFG_FORCE];
        end
      end
    end

    // hardware sync source chosen by the select field
    case (s_r.sync_sel)
      3'h0: sel_hit = pwm_timer_sync[0];
      3'h1: sel_hit = pwm_timer_sync[1];
      3'h2: sel_hit = pwm_timer_sync[2];
      `ICU_SYNC_SEL_EXT: sel_hit = ext_sync_s & ~s_r.ext_prev;
      default: sel_hit = 1'b0;
    endcase
    s_nxt.ext_prev = ext_sync_s;
    // software sync acts whatever the enable; hardware sync needs it
    sync_evt = s_r.sw_sync | (s_r.sync_en & sel_hit);

    // timer on pclk: sync load wins over counting
    if (sync_evt) begin
      s_nxt.timer = s_r.phase;
    end else if (s_r.timer_en) begin
      s_nxt.timer = s_r.timer + 32'h0000_0001;
    end

    // time-stamp, edge record and interrupt pulse per capture
    s_nxt.irq = '0;
    for (int i = 0; i < `ICU_NUM_CH; i++) begin
      if (ch_capture[i]) begin
        s_nxt.stamp[i] = s_r.timer;
        s_nxt.last_edge[i] = ch_edge_fall[i];
        s_nxt.irq[i] = 1'b1;
      end
    end
  end

  // all state in one register bank
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      s_r <= '0;
    end else begin
      s_r <= s_nxt;
    end
  end

  // outputs straight from flops
  assign prdata = s_r.prdata;
  assign pready = s_r.pready;
  assign pslverr = s_r.pslverr;
  assign capture_irq = s_r.irq;

endmodule // icu_top

// ---- tb/icu_pad_model.sv ----
/* pad model: one shared pad pulsed on request and routed to the capture inputs.
   assumes the bench gives go for one cycle with the pulse count. */
`timescale 1ns/1ns
module icu_pad_model (
  input wire logic pclk,
  input wire logic go,
  input wire logic [8:0] pulses,
  input wire logic [2:0] route,
  output logic [2:0] pads,
  output logic busy
);
  logic [9:0] left_r = 10'h000;
  logic [1:0] ph_r = 2'h0;
  logic pad_r = 1'b0;
  // each level held 4 clocks, changed just after an edge
  always @(posedge pclk) begin
    if (go) begin
      left_r <= {pulses, 1'b0};
      ph_r <= 2'h0;
    end else if (left_r != 10'h000) begin
      ph_r <= ph_r + 2'h1;
      if (ph_r == 2'h3) begin
        pad_r <= ~pad_r;
        left_r <= left_r - 10'h001;
      end
    end
  end
  // unrouted inputs rest low
  assign pads = route & {3{pad_r}};
  assign busy = left_r != 10'h000;
endmodule // icu_pad_model

// ---- tb/icu_monitor.sv ----
/* checker of the capture unit's bus answers and capture pulses.
   assumes it is bound to icu_top. */
`timescale 1ns/1ns
module icu_monitor (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic [7:0] paddr,
  input wire logic psel,
  input wire logic penable,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic capture_input_a,
  input wire logic capture_input_b,
  input wire logic capture_input_c,
  input wire logic [2:0] capture_irq
);
  logic [2:0] pads_r;
  logic [3:0] quiet_r;
  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);
  // cycles since the pads or the bus last moved
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pads_r <= 3'h0;
      quiet_r <= 4'h0;
    end else begin
      pads_r <= {capture_input_c, capture_input_b, capture_input_a};
      if (psel || pads_r != {capture_input_c, capture_input_b, capture_input_a}) quiet_r <= 4'h0;
      else if (quiet_r != 4'hF) quiet_r <= quiet_r + 4'h1;
    end
  end
  a_one_wait: assert property (psel && penable && !pready |=> pready) else $error("no answer");
  a_ready_pulse: assert property (pready |=> !pready) else $error("long ready");
  a_ready_cause: assert property (pready |-> $past(psel && penable)) else $error("stray ready");
  a_err_unmapped: assert property (pready && (paddr > 8'h24 || paddr[1:0] != 2'h0) |-> pslverr)
    else $error("no error");
  a_ok_mapped: assert property (pready && paddr <= 8'h24 && paddr[1:0] == 2'h0 |-> !pslverr)
    else $error("false error");
  a_err_gated: assert property (pslverr |-> pready) else $error("stray error");
  a_rdata_idle: assert property (!pready |-> prdata == 32'h0) else $error("data idle");
  a_irq_cause: assert property (quiet_r >= 4'h7 |-> capture_irq == 3'h0) else $error("stray irq");
  c_err: cover property (pslverr);
  c_irq: cover property (capture_irq[0]);
  c_all: cover property (&capture_irq);
endmodule // icu_monitor

// ---- tb/testbench.sv ----
/* testbench of the capture unit: apb tasks, pad model, random and corner cases.
   assumes icu_top, icu_pad_model and icu_monitor are compiled first. */
`timescale 1ns/1ns
module testbench;
  logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, ext_sync_in = 0, go = 0, busy, pready, pslverr, e;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0, prdata, q, v, ph;
  logic [2:0] pwm_timer_sync = 3'h0, capture_irq, pads, route = 3'h0;
  logic [8:0] pulses = 9'h000;
  int seed = 28, bad_count = 0, checks = 0, cyc = 0, tq, cs, i;
  int cnt [3] = '{0, 0, 0};
  int base [3];
  int p [3];
  icu_top u_icu_top (.pclk(pclk), .presetn(presetn), .paddr(paddr), .psel(psel), .penable(penable),
    .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .capture_input_a(pads[0]), .capture_input_b(pads[1]), .capture_input_c(pads[2]),
    .pwm_timer_sync(pwm_timer_sync), .ext_sync_in(ext_sync_in), .capture_irq(capture_irq));
  icu_pad_model u_icu_pad_model (.pclk(pclk), .go(go), .pulses(pulses), .route(route), .pads(pads), .busy(busy));
  always #25 pclk = ~pclk;
  // cycle count and capture pulses per channel
  always @(posedge pclk) begin
    cyc <= cyc + 1;
    for (int k = 0; k < 3; k++) cnt[k] <= cnt[k] + (capture_irq[k] === 1'b1);
  end
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks++;
    if (got !== exp) begin
      bad_count++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  // one apb transfer; q, e and tq keep data, error and cycle of the answer
  task automatic apb(input logic [7:0] a, input logic w, input logic [31:0] d);
    @(posedge pclk);
    paddr <= a;
    pwrite <= w;
    pwdata <= d;
    psel <= 1'b1;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
    end while (pready !== 1'b1);
    q = prdata;
    e = pslverr;
    tq = cyc;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  // n pad pulses on the routed inputs, then time to settle
  task automatic pulse(input logic [2:0] r, input logic [8:0] n);
    @(posedge pclk);
    route <= r;
    pulses <= n;
    go <= 1'b1;
    @(posedge pclk);
    go <= 1'b0;
    do begin
      @(posedge pclk);
    end while (busy);
    repeat (8) @(posedge pclk);
  endtask
  task automatic print_verdict;
    $display("checks=%0d bad_count=%0d", checks, bad_count);
    if (bad_count == 0 && checks > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask
  // watchdog
  initial begin
    #1000000;
    bad_count++;
    print_verdict;
  end
  initial begin
    repeat (6) @(posedge pclk);
    presetn <= 1'b1;
    // reset values, then unmapped and misaligned places
    for (i = 0; i <= 36; i += 4) begin
      apb(i[7:0], 1'b0, 32'h0);
      chk(q, 32'h0);
      chk({31'h0, e}, 32'h0);
    end
    apb(8'h28, 1'b0, 32'h0);
    chk({31'h0, e}, 32'h1);
    apb(8'h06, 1'b0, 32'h0);
    chk({31'h0, e}, 32'h1);
    // read-only stamp ignores writes; config reads back
    v = $random(seed);
    apb(8'h14, 1'b1, v);
    apb(8'h14, 1'b0, 32'h0);
    chk(q, 32'h0);
    apb(8'h08, 1'b1, v & 32'h0000_0FFF);
    apb(8'h08, 1'b0, 32'h0);
    chk(q, v & 32'h0000_0FFF);
    apb(8'h08, 1'b1, 32'h0);
    // timer difference equals cycles between answers
    apb(8'h00, 1'b1, 32'h1);
    apb(8'h24, 1'b0, 32'h0);
    v = q;
    cs = tq;
    apb(8'h24, 1'b0, 32'h0);
    chk(q - v, tq - cs);
    // each sync source loads the phase; step 4 is the software request
    ph = $random(seed);
    apb(8'h04, 1'b1, ph);
    for (i = 0; i < 5; i++) begin
      apb(8'h00, 1'b1, i < 4 ? 32'h3 | (i << 2) : 32'h21);
      @(posedge pclk);
      if (i < 3) pwm_timer_sync[i] <= 1'b1;
      if (i == 3) ext_sync_in <= 1'b1;
      cs = cyc;
      @(posedge pclk);
      pwm_timer_sync <= 3'h0;
      apb(8'h24, 1'b0, 32'h0);
      v = q - ph - (tq - cs) + 32'h8;
      chk({31'h0, v < 32'h10}, 32'h1);
      ext_sync_in <= 1'b0;
    end
    // command bit reads back as zero
    apb(8'h00, 1'b0, 32'h0);
    chk(q, 32'h1);
    // one pad into all channels, each with its own random ratio
    for (i = 0; i < 3; i++) begin
      p[i] = $random(seed) & 3;
      apb(8'h08 + 8'(4 * i), 1'b1, 32'h3 | (p[i] << 3));
      base[i] = cnt[i];
    end
    pulse(3'h7, 9'h008);
    for (i = 0; i < 3; i++) chk(cnt[i] - base[i], 8 / (p[i] + 1));
    // largest ratio lets one edge in 256 through
    for (i = 0; i < 3; i++) apb(8'h08 + 8'(4 * i), 1'b1, 32'h0);
    apb(8'h08, 1'b1, 32'h0000_07FB);
    for (i = 0; i < 3; i++) base[i] = cnt[i];
    pulse(3'h7, 9'h0FF);
    chk(cnt[0] - base[0], 0);
    chk(cnt[1] - base[1], 0);
    chk(cnt[2] - base[2], 0);
    pulse(3'h1, 9'h001);
    chk(cnt[0] - base[0], 1);
    // inverted rise, plain fall and plain rise on one pulse
    apb(8'h08, 1'b1, 32'h0);
    apb(8'h08, 1'b1, 32'h0000_0803);
    apb(8'h0C, 1'b1, 32'h0000_0005);
    apb(8'h10, 1'b1, 32'h0000_0003);
    repeat (8) @(posedge pclk);
    for (i = 0; i < 3; i++) base[i] = cnt[i];
    pulse(3'h7, 9'h001);
    for (i = 0; i < 3; i++) chk(cnt[i] - base[i], 1);
    apb(8'h20, 1'b0, 32'h0);
    chk(q & 32'h7, 32'h2);
    apb(8'h14, 1'b0, 32'h0);
    v = q;
    apb(8'h18, 1'b0, 32'h0);
    chk(q, v);
    apb(8'h1C, 1'b0, 32'h0);
    chk(v - q, 32'h4);
    // forced capture on c: new stamp and pulse, edge record kept
    ph = q;
    base[2] = cnt[2];
    apb(8'h10, 1'b1, 32'h0000_1003);
    repeat (6) @(posedge pclk);
    chk(cnt[2] - base[2], 1);
    apb(8'h1C, 1'b0, 32'h0);
    chk({31'h0, q != ph}, 32'h1);
    apb(8'h20, 1'b0, 32'h0);
    chk(q & 32'h7, 32'h2);
    chk(q >> 3, 32'h8);
    print_verdict;
  end
endmodule // testbench
bind icu_top icu_monitor u_icu_monitor (.pclk(pclk), .presetn(presetn), .paddr(paddr), .psel(psel),
  .penable(penable), .prdata(prdata), .pready(pready), .pslverr(pslverr), .capture_input_a(capture_input_a),
  .capture_input_b(capture_input_b), .capture_input_c(capture_input_c), .capture_irq(capture_irq));
